// ==== common/odcg_pkg.sv ====
// package for the display clock generator: register map, widths, timing
// assumes a 32-bit apb slave bus and one system clock
`default_nettype none
package odcg_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ODCG_TARGET_OFS = 12'h000;
  localparam logic [11:0] ODCG_MATCH_OFS = 12'h004;
  localparam logic [11:0] ODCG_STATUS_OFS = 12'h008;
  localparam logic [11:0] ODCG_CTRL_OFS = 12'h00c;
  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int ODCG_CNT_W = 11;
  localparam int ODCG_TGT_W = 8;
  localparam int ODCG_LOW_BITS = 3;
  localparam int ODCG_STAT_LOCK_BIT = 0;
  localparam int ODCG_STAT_RUN_BIT = 1;
  localparam int ODCG_CTRL_STOP_BIT = 0;
  localparam logic [7:0] ODCG_TARGET_RST = 8'h00;
  localparam logic [7:0] ODCG_MATCH_ALL = 8'hff;
  // ---------------------------------------------------------------
  // oscillator model and timing
  // ---------------------------------------------------------------
  localparam int ODCG_CLK_MHZ = 40;
  localparam int ODCG_FMIN_MHZ = 8;
  localparam int ODCG_FMAX_MHZ = 24;
  localparam int ODCG_PH_W = 16;
  localparam logic [15:0] ODCG_STEP_MIN =
    16'((ODCG_FMIN_MHZ * 65536) / ODCG_CLK_MHZ);
  localparam logic [15:0] ODCG_STEP_MAX =
    16'((ODCG_FMAX_MHZ * 65536) / ODCG_CLK_MHZ);
  localparam logic [15:0] ODCG_STEP_INC = 16'h0010;
  localparam logic [15:0] ODCG_STEP_START = 16'h8000;
  localparam int ODCG_SETTLE_LINES = 256;
  localparam int ODCG_LINE_CNT_W = 9;
  typedef enum logic [1:0] {ODCG_IDLE, ODCG_TRACK, ODCG_LOCKED}
    odcg_state_t;
endpackage
`default_nettype wire

// ==== common/odcg_meas_if.sv ====
// carrier between controller and measurement counter
// assumes both ends run on sys_clk
`timescale 1ns/100ps
`default_nettype none
interface odcg_meas_if;
  logic osc_tick;
  logic line_done;
  logic [7:0] count_upper;
  logic [10:0] count_full;
  modport ctrl (output osc_tick, input line_done, count_upper, count_full);
  modport meas (input osc_tick, output line_done, count_upper, count_full);
endinterface
`default_nettype wire

// ==== logic/odcg_ring_osc.sv ====
// numerically controlled stand-in for the ring oscillator
// assumes sys_clk fast enough for the 24 mhz top of range
`timescale 1ns/100ps
`default_nettype none
module odcg_ring_osc
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [15:0] step,
  output logic tick,
  output logic osc_clk
);
  logic [15:0] phase_reg;
  logic [16:0] sum;
  assign sum = {1'b0, phase_reg} + {1'b0, step};
  always_ff @(posedge sys_clk)
  begin
    if (srst || !run)
    begin
      phase_reg <= 16'h0000;
      tick <= 1'b0;
      osc_clk <= 1'b0;
    end
    else
    begin
      phase_reg <= sum[15:0];
      tick <= sum[16];
      osc_clk <= sum[15];
    end
  end
endmodule
`default_nettype wire

// ==== logic/odcg_counter.sv ====
// counts oscillator ticks over each sync high period
// assumes horizontal_sync_in is synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module odcg_counter
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic horizontal_sync_in,
  odcg_meas_if.meas meas
);
  logic sync_d_reg;
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  wire sync_rise = horizontal_sync_in & ~sync_d_reg;
  wire sync_fall = ~horizontal_sync_in & sync_d_reg;
  assign cnt_next = (cnt_reg == 11'h7ff) ? cnt_reg : cnt_reg + 11'h001;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync_d_reg <= 1'b0;
      cnt_reg <= 11'h000;
      meas.line_done <= 1'b0;
      meas.count_upper <= 8'h00;
      meas.count_full <= 11'h000;
    end
    else
    begin
      sync_d_reg <= horizontal_sync_in;
      meas.line_done <= sync_fall;
      if (sync_rise)
        cnt_reg <= 11'h000;
      else if (horizontal_sync_in && meas.osc_tick)
        cnt_reg <= cnt_next;
      if (sync_fall)
      begin
        meas.count_upper <= cnt_reg[10:3];
        meas.count_full <= cnt_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/odcg_top.sv ====
// display clock generator locked to the horizontal sync high period
// assumes apb master on sys_clk and sync synchronous to sys_clk
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module odcg_top
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic horizontal_sync_in,
  input wire logic cpu_stop_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic osc_clk,
  output logic osc_running,
  output logic osc_locked
);
  // ---------------------------------------------------------------
  // registers and interconnect
  // ---------------------------------------------------------------
  odcg_meas_if meas_bus ();
  odcg_pkg::odcg_state_t state_reg;
  odcg_pkg::odcg_state_t state_next;
  logic [7:0] target_reg;
  logic [7:0] match_reg;
  logic [15:0] step_reg;
  logic [15:0] step_next;
  logic [8:0] line_cnt_reg;
  logic [15:0] probe_reg;
  logic [15:0] probe_next;
  logic [15:0] step_eff;
  logic skip_reg;
  logic [31:0] prdata_next;
  logic osc_tick;
  logic osc_clk_raw;
  logic [7:0] match_now;
  logic stop_unused;
  wire run = (target_reg != odcg_pkg::ODCG_TARGET_RST);
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  wire sel_tgt = (paddr == odcg_pkg::ODCG_TARGET_OFS);
  wire sel_match = (paddr == odcg_pkg::ODCG_MATCH_OFS);
  wire sel_stat = (paddr == odcg_pkg::ODCG_STATUS_OFS);
  wire sel_ctrl = (paddr == odcg_pkg::ODCG_CTRL_OFS);
  wire mapped = sel_tgt | sel_match | sel_stat | sel_ctrl;
  wire tgt_wr = wr_acc & sel_tgt & ~pready;
  assign stop_unused = cpu_stop_mode;
  // ---------------------------------------------------------------
  // oscillator and measurement
  // ---------------------------------------------------------------
  odcg_ring_osc u_osc
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(run),
    .step(step_eff),
    .tick(osc_tick),
    .osc_clk(osc_clk_raw)
  );
  assign meas_bus.osc_tick = osc_tick;
  odcg_counter u_cnt
  (
    .sys_clk(sys_clk),
    .srst(srst | tgt_wr),
    .horizontal_sync_in(horizontal_sync_in),
    .meas(meas_bus)
  );
  // ---------------------------------------------------------------
  // comparator and controller
  // ---------------------------------------------------------------
  assign match_now = ~(target_reg ^ meas_bus.count_upper);
  wire coincide = (match_now == odcg_pkg::ODCG_MATCH_ALL);
  wire too_slow = meas_bus.count_upper < target_reg;
  wire at_max = (step_reg >= odcg_pkg::ODCG_STEP_MAX);
  wire at_min = (step_reg <= odcg_pkg::ODCG_STEP_MIN);
  wire give_up = (line_cnt_reg ==
    9'(odcg_pkg::ODCG_SETTLE_LINES - 1));
  // binary search on the step keeps settling far inside 256 lines
  wire [15:0] step_base = too_slow ? step_reg : (step_reg & ~probe_reg);
  wire [15:0] step_try = step_base | (probe_reg >> 1);
  // clamp the search value to the legal oscillator range
  assign step_eff = at_max ? odcg_pkg::ODCG_STEP_MAX :
    (at_min ? odcg_pkg::ODCG_STEP_MIN : step_reg);
  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    probe_next = probe_reg;
    unique case (state_reg)
      odcg_pkg::ODCG_IDLE:
      begin
        if (run)
          state_next = odcg_pkg::ODCG_TRACK;
      end
      odcg_pkg::ODCG_TRACK:
      begin
        if (meas_bus.line_done && !skip_reg)
        begin
          if (coincide || give_up || probe_reg == 16'h0000)
            state_next = odcg_pkg::ODCG_LOCKED;
          else
          begin
            step_next = step_try;
            probe_next = probe_reg >> 1;
          end
        end
      end
      odcg_pkg::ODCG_LOCKED:
      begin
        state_next = odcg_pkg::ODCG_LOCKED;
      end
      default:
      begin
        state_next = odcg_pkg::ODCG_IDLE;
      end
    endcase
    if (tgt_wr)
    begin
      state_next = (pwdata[7:0] == odcg_pkg::ODCG_TARGET_RST) ?
        odcg_pkg::ODCG_IDLE : odcg_pkg::ODCG_TRACK;
      step_next = odcg_pkg::ODCG_STEP_START;
      probe_next = odcg_pkg::ODCG_STEP_START;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= odcg_pkg::ODCG_IDLE;
      step_reg <= odcg_pkg::ODCG_STEP_MIN;
      line_cnt_reg <= 9'h000;
      probe_reg <= 16'h0000;
      skip_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      probe_reg <= probe_next;
      // the first line after a write may be cut short, so it is ignored
      if (tgt_wr)
        skip_reg <= 1'b1;
      else if (meas_bus.line_done)
        skip_reg <= 1'b0;
      if (tgt_wr)
        line_cnt_reg <= 9'h000;
      else if (meas_bus.line_done && state_reg == odcg_pkg::ODCG_TRACK)
        line_cnt_reg <= line_cnt_reg + 9'h001;
    end
  end
  // ---------------------------------------------------------------
  // register file and apb answer
  // ---------------------------------------------------------------
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (sel_tgt)
      prdata_next = {24'h000000, target_reg};
    else if (sel_match)
      prdata_next = {24'h000000, match_reg};
    else if (sel_stat)
      prdata_next = {30'h0000_0000, run,
        state_reg == odcg_pkg::ODCG_LOCKED};
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      target_reg <= odcg_pkg::ODCG_TARGET_RST;
      match_reg <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      osc_clk <= 1'b0;
      osc_running <= 1'b0;
      osc_locked <= 1'b0;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready & ~pwrite) ? prdata_next : 32'h0000_0000;
      if (tgt_wr)
        target_reg <= pwdata[7:0];
      if (meas_bus.line_done)
        match_reg <= match_now;
      osc_clk <= osc_clk_raw & run;
      osc_running <= run | stop_unused & run;
      osc_locked <= (state_reg == odcg_pkg::ODCG_LOCKED);
    end
  end
endmodule
`default_nettype wire

// ==== tb/odcg_props.sv ====
// port checker for odcg_top
// bound below, one sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module odcg_props
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_running,
  input wire logic osc_locked
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  wire logic sel = psel && pwrite && paddr == 12'h000;
  wire logic tw = sel && penable && !pready;
  property p_rdy;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no pready");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("lone pslverr");
  property p_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero");
  property p_stop;
    tw && pwdata[7:0] == 8'h00 |=> ##[0:2] !osc_running;
  endproperty
  a_stop: assert property (p_stop) else $error("still running");
  property p_start;
    tw && pwdata[7:0] != 8'h00 |=> ##[0:2] osc_running && !osc_locked;
  endproperty
  a_start: assert property (p_start) else $error("no restart");
  property p_run;
    osc_running && !sel && !$past(sel) |=> osc_running;
  endproperty
  a_run: assert property (p_run) else $error("run dropped");
  property p_lock;
    osc_locked && !sel && !$past(sel) |=> osc_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock dropped");
endmodule
bind odcg_top odcg_props u_props (.sys_clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_running,
  .osc_locked);
`default_nettype wire

// ==== tb/odcg_sync_src.sv ====
// sync source model for the bench
// free running from sys_clk while run is high
`timescale 1ns/100ps
`default_nettype none
module odcg_sync_src
(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [15:0] high_len,
  input wire logic [15:0] line_len,
  output logic sync
);
  logic [15:0] pos_reg = 16'h0000;
  wire logic wrap = !run || pos_reg >= line_len - 16'h0001;
  always_ff @(posedge sys_clk)
  begin
    pos_reg <= wrap ? 16'h0000 : pos_reg + 16'h0001;
    sync <= run && pos_reg < high_len;
  end
endmodule
`default_nettype wire

// ==== tb/osd_display_clock_generator_test.sv ====
// bench for odcg_top: apb master tasks and a sync source
// assumes a 40 mhz sys_clk and the odcg_pkg register map
`timescale 1ns/100ps
`default_nettype none
module osd_display_clock_generator_test;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic stop_mode = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic run = 1'b0;
  logic [15:0] hi = 16'h0096;
  logic [15:0] len = 16'h012c;
  logic [31:0] prdata, rd;
  logic pready, pslverr, osc_clk, osc_running, osc_locked, sync, e;
  int err_total = 0;
  int samples_checked = 0;
  int t;
  odcg_top DUT (.sys_clk, .srst, .horizontal_sync_in(sync),
    .cpu_stop_mode(stop_mode), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .osc_clk, .osc_running, .osc_locked);
  odcg_sync_src u_src (.sys_clk, .run, .high_len(hi), .line_len(len),
    .sync);
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(logic [31:0] x, logic [31:0] y, string nm);
    samples_checked++;
    if (y !== x)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(logic [11:0] a, logic [31:0] x, logic f, string nm);
    apb(1'b0, a, 32'h0);
    chk(x, rd, nm);
    chk({31'h0, f}, {31'h0, e}, "pslverr");
  endtask
  task automatic toggles();
    logic v = osc_clk;
    t = 0;
    repeat (64)
    begin
      @(posedge sys_clk);
      t += int'(osc_clk !== v);
      v = osc_clk;
    end
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
      rchk(12'(4 * i), 32'h0, 1'b0, "reset value");
    apb(1'b1, 12'h010, 32'h33);
    rchk(12'h010, 32'h0, 1'b1, "unmapped");
    rchk(12'h000, 32'h0, 1'b0, "target");
  endtask
  task automatic t_lock();
    int k = 0;
    stop_mode <= 1'b1;
    run <= 1'b1;
    apb(1'b1, 12'h000, 32'h08);
    apb(1'b1, 12'h000, 32'h08);
    while (osc_locked !== 1'b1 && k < 258)
    begin
      @(negedge sync);
      k++;
    end
    repeat (3) @(posedge sys_clk);
    chk(32'h1, {31'h0, osc_locked}, "locked");
    apb(1'b0, 12'h004, 32'h0);
    chk(32'hf8, rd & 32'hf8, "match high");
    rchk(12'h008, 32'h3, 1'b0, "status");
    toggles();
    chk(32'h1, {31'h0, t > 48 && t < 63}, "osc rate");
  endtask
  task automatic t_rewrite();
    run <= 1'b0;
    apb(1'b1, 12'h000, 32'h08);
    rchk(12'h008, 32'h2, 1'b0, "status");
  endtask
  task automatic t_xnor();
    hi <= 16'h0002;
    len <= 16'h0014;
    apb(1'b1, 12'h000, 32'ha5);
    run <= 1'b1;
    @(negedge sync);
    run <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(12'h004, 32'h5a, 1'b0, "match");
  endtask
  task automatic t_stop();
    apb(1'b1, 12'h000, 32'h0);
    rchk(12'h008, 32'h0, 1'b0, "status");
    toggles();
    chk(32'h0, 32'(t), "stopped clock");
  endtask
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (99000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_lock();
    t_rewrite();
    t_xnor();
    t_stop();
    finish_test();
  end
endmodule
`default_nettype wire
